// [ipf_pkg.sv]
// constants and types shared by the instruction prefetch front end
package ipf_pkg;
  // address layout, most significant address bit is bit 23 of the vector
  localparam int IPF_AW = 24;
  localparam int IPF_PAR_BIT = 3;
  localparam int IPF_DW_LO = 3;
  localparam logic [23:0] IPF_INC_DW = 24'h000008;
  localparam logic [23:0] IPF_INC_2DW = 24'h000010;
  localparam logic [23:0] IPF_CTR_RST = 24'h000000;
  // front opcode register fields
  localparam int IPF_OP_HI = 31;
  localparam int IPF_OP_LO = 24;
  localparam int IPF_RF_HI = 23;
  localparam int IPF_RF_LO = 20;
  localparam int IPF_L2_HI = 19;
  localparam int IPF_L2_LO = 16;
  localparam logic [1:0] IPF_FMT_RR = 2'h0;
  localparam logic [1:0] IPF_FMT_SS = 2'h3;
  // register map
  localparam logic [7:0] IPF_OFF_COUNTER = 8'h00;
  localparam logic [7:0] IPF_OFF_STATUS = 8'h04;
  localparam logic [7:0] IPF_OFF_FRONT = 8'h08;
  localparam logic [7:0] IPF_OFF_OPCODES = 8'h0C;
  localparam logic [7:0] IPF_OFF_LENGTHS = 8'h10;
  localparam logic [7:0] IPF_OFF_CTRL = 8'h14;
  localparam int IPF_CTRL_EN = 0;
  localparam logic IPF_EN_RST = 1'b0;

  typedef enum logic [1:0] {
    IPF_FS_IDLE = 2'h0,
    IPF_FS_REQ = 2'h1
  } ipf_fetch_state_type;

  // instruction length in halfwords from the first two opcode bits
  function automatic logic [2:0] ipf_ilen(input logic [1:0] fmt);
    logic [2:0] len;
    len = (fmt == IPF_FMT_RR) ? 3'h1 : ((fmt == IPF_FMT_SS) ? 3'h3 : 3'h2);
    return len;
  endfunction
endpackage

// [ipf_buf_reg.sv]
// one instruction buffer register with its valid flag
`timescale 1ns/1ps
`default_nettype none
module ipf_buf_reg
  import ipf_pkg::*;
#(
  parameter int W = 64
) (
  input wire logic pclk, // machine clock
  input wire logic presetn, // async reset, low
  input wire logic load, // write fetched word
  input wire logic [W-1:0] load_data, // fetched word
  input wire logic clear, // buffer consumed
  output logic [W-1:0] data, // held word
  output logic valid // word present
);
  logic [W-1:0] data_q, data_d;
  logic valid_q, valid_d;

  // set wins over clear so a landing word is never lost
  always_comb begin
    data_d = load ? load_data : data_q;
    valid_d = load ? 1'b1 : (clear ? 1'b0 : valid_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= '0;
      valid_q <= 1'b0;
    end else begin
      data_q <= data_d;
      valid_q <= valid_d;
    end
  end

  assign data = data_q;
  assign valid = valid_q;

  property p_buf_set_wins;
    @(posedge pclk) disable iff (!presetn) load |=> valid_q && (data_q == $past(load_data));
  endproperty
  a_buf_set_wins: assert property (p_buf_set_wins) else $error("buffer load lost");
endmodule
`default_nettype wire

// [ipf_len_ctr.sv]
// operand length down counter for storage-to-storage work
`timescale 1ns/1ps
`default_nettype none
module ipf_len_ctr
  import ipf_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic pclk, // machine clock
  input wire logic presetn, // async reset, low
  input wire logic load, // take length field
  input wire logic [W-1:0] load_val, // length field
  input wire logic dec, // one byte processed
  output logic [W-1:0] count, // bytes left minus one
  output logic done // operand exhausted
);
  logic [W-1:0] count_q, count_d;
  logic done_q, done_d;

  // field holds length minus one, so a step at zero exhausts it
  always_comb begin
    count_d = count_q;
    done_d = done_q;
    if (load) begin
      count_d = load_val;
      done_d = 1'b0;
    end else if (dec && !done_q) begin
      if (count_q == '0) begin
        done_d = 1'b1;
      end else begin
        count_d = count_q - W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      done_q <= 1'b1;
    end else begin
      count_q <= count_d;
      done_q <= done_d;
    end
  end

  assign count = count_q;
  assign done = done_q;

  property p_len_step;
    @(posedge pclk) disable iff (!presetn)
      (!load && dec && !done_q && count_q != '0) |=> count_q == $past(count_q) - W'(1);
  endproperty
  a_len_step: assert property (p_len_step) else $error("length count did not step");
endmodule
`default_nettype wire

// [ipf_top.sv]
// instruction prefetch, halfword gating and opcode staging front end
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ipf_top
  import ipf_pkg::*;
(
  input wire logic pclk, // machine clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic fetch_req, // storage fetch request
  output logic [20:0] fetch_dw_addr, // double word address
  output logic fetch_route, // return route used
  input wire logic fetch_ack, // controller took request
  input wire logic ret_valid, // word returning
  input wire logic ret_route, // route of returning word
  input wire logic [63:0] ret_data, // returning double word
  input wire logic dispatch_ready, // exec takes next op
  input wire logic first_exec_cycle, // first exec cycle
  input wire logic third_hw_need, // exec wants third halfword
  input wire logic len1_dec, // first operand byte done
  input wire logic len2_dec, // second operand byte done
  output logic dispatch, // op moved to exec, pulse
  output logic [11:0] fast_exec_opcode, // opcode and reg field
  output logic [7:0] exec_stage_opcode, // exec opcode
  output logic [7:0] last_cycle_opcode, // final cycle opcode
  output logic [3:0] putaway_reg_select, // result register
  output logic [15:0] exec_operand_hw, // second or third halfword
  output logic [3:0] first_operand_len, // first length counter
  output logic [3:0] second_operand_len, // second length counter
  output logic ss_done // both operands exhausted, pulse
);
  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  logic [23:0] ctr_q, ctr_d;
  logic [23:0] addr_latch_q, addr_d;
  logic enable_q, enable_d;
  logic front_valid_q, front_valid_d;
  logic [31:0] front_q, front_d;
  logic [15:0] third_q, third_d;
  logic [1:0] pend_q, pend_d;
  ipf_fetch_state_type fs_q, fs_d;
  logic fetch_req_q, req_d;
  logic route_sel_q, rsel_d;
  logic [1:0] route_busy_q, busy_d, route_tgt_q, tgt_d, route_stale_q, stale_d;
  logic req_stale_q, rstale_d;
  logic [63:0] ret_latch_q, ret_latch_d;
  logic ret_vld_q, ret_route_q;
  logic [11:0] fast_q, fast_d;
  logic [7:0] exec_q, exec_d, last_q, last_d;
  logic [3:0] put_q, put_d;
  logic [15:0] op2_q, op2_d, op3_q, op3_d, opnd_q, opnd_d;
  logic is3_q, is3_d, disp_q, ss_act_q, ss_act_d, ss_done_q, ss_done_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [1:0] buf_set, buf_clr, buf_vld;
  logic [63:0] buf_data [2];
  logic [15:0] ring_hw [8];
  logic ring_vld [8];
  logic [3:0] len1_cnt, len2_cnt;
  logic len1_done, len2_done;

  // ----------------------------------------------------------------
  // buffer ring and gate select decode
  // ----------------------------------------------------------------
  for (genvar b = 0; b < 2; b++) begin : g_buf
    ipf_buf_reg #(.W(64)) u_buf (
      .pclk(pclk),
      .presetn(presetn),
      .load(buf_set[b]),
      .load_data(ret_latch_q),
      .clear(buf_clr[b]),
      .data(buf_data[b]),
      .valid(buf_vld[b])
    );
  end

  // halfword 0 is the left end of the even buffer, 7 the right of the odd
  for (genvar g = 0; g < 8; g++) begin : g_ring
    assign ring_hw[g] = buf_data[g / 4][63 - 16 * (g % 4) -: 16];
    assign ring_vld[g] = buf_vld[g / 4];
  end

  logic [2:0] gs, idx1, idx2, gate_len, front_len;
  logic [3:0] gs_sum;
  logic need_ok, can_gate, redirect, apb_done, own, oth, hit3, hit7, do_disp;
  assign gs = ctr_q[3:1];
  assign idx1 = gs + 3'h1;
  assign idx2 = gs + 3'h2;
  assign gate_len = ipf_ilen(ring_hw[gs][15:14]);
  assign front_len = ipf_ilen(front_q[IPF_OP_HI -: 2]);
  assign gs_sum = {1'b0, gs} + {1'b0, front_len};
  // only halfwords the instruction really spans must be present
  assign need_ok = ring_vld[gs] && (gate_len < 3'h2 || ring_vld[idx1])
                   && (gate_len < 3'h3 || ring_vld[idx2]);
  assign can_gate = enable_q && !front_valid_q && need_ok && !redirect;
  assign do_disp = front_valid_q && dispatch_ready && !redirect;
  assign hit3 = gs == 3'h3 || (gate_len > 3'h1 && idx1 == 3'h3)
                || (gate_len > 3'h2 && idx2 == 3'h3);
  assign hit7 = gs == 3'h7 || (gate_len > 3'h1 && idx1 == 3'h7)
                || (gate_len > 3'h2 && idx2 == 3'h7);
  assign own = ctr_q[IPF_PAR_BIT];
  assign oth = ~ctr_q[IPF_PAR_BIT];
  assign apb_done = psel && penable && pready_q;
  assign redirect = apb_done && pwrite && paddr == IPF_OFF_COUNTER;

  // ----------------------------------------------------------------
  // counter, front opcode register and buffer release
  // ----------------------------------------------------------------
  // a buffer is released as soon as its last halfword is gated,
  // which lets the refill start while that instruction still waits
  always_comb begin
    ctr_d = ctr_q;
    front_valid_d = front_valid_q;
    front_d = front_q;
    third_d = third_q;
    buf_clr = 2'b00;
    if (redirect) begin
      ctr_d = {pwdata[23:1], 1'b0};
      front_valid_d = 1'b0;
      buf_clr = 2'b11;
    end else if (do_disp) begin
      // new gate select copied back, carry goes in at bit 4
      ctr_d = {ctr_q[23:4] + {19'h0, gs_sum[3]}, gs_sum[2:0], 1'b0};
      front_valid_d = 1'b0;
    end else if (can_gate) begin
      front_valid_d = 1'b1;
      front_d[31:16] = ring_hw[gs];
      front_d[15:0] = (gate_len == 3'h1) ? 16'h0000 : ring_hw[idx1];
      third_d = (gate_len == 3'h3) ? ring_hw[idx2] : 16'h0000;
      buf_clr = {hit7, hit3};
    end
  end

  // ----------------------------------------------------------------
  // fetch issue, return routes and return latch
  // ----------------------------------------------------------------
  // fetch priority: the word under the counter when nothing is gated,
  // then the next word (plus 8), then the one after (plus 16)
  always_comb begin
    fs_d = fs_q;
    req_d = fetch_req_q;
    addr_d = addr_latch_q;
    pend_d = pend_q;
    rsel_d = route_sel_q;
    busy_d = route_busy_q;
    tgt_d = route_tgt_q;
    stale_d = route_stale_q;
    rstale_d = req_stale_q;
    buf_set = 2'b00;
    ret_latch_d = ret_valid ? ret_data : ret_latch_q;
    if (ret_vld_q && route_busy_q[ret_route_q]) begin
      busy_d[ret_route_q] = 1'b0;
      if (!route_stale_q[ret_route_q] && !redirect) begin
        buf_set[route_tgt_q[ret_route_q]] = 1'b1;
        pend_d[route_tgt_q[ret_route_q]] = 1'b0;
      end
    end
    // words already on their way for the old stream are thrown away
    if (redirect) begin
      pend_d = 2'b00;
      stale_d = busy_d;
      rstale_d = fetch_req_q;
    end
    case (fs_q)
      IPF_FS_IDLE: begin
        if (enable_q && !redirect && !route_busy_q[route_sel_q]) begin
          if (!front_valid_q && !buf_vld[own] && !pend_q[own]) begin
            addr_d = ctr_q;
            pend_d[own] = 1'b1;
            req_d = 1'b1;
            fs_d = IPF_FS_REQ;
          end else if (!buf_vld[oth] && !pend_q[oth]) begin
            addr_d = ctr_q + IPF_INC_DW;
            pend_d[oth] = 1'b1;
            req_d = 1'b1;
            fs_d = IPF_FS_REQ;
          end else if (!buf_vld[own] && !pend_q[own]) begin
            addr_d = ctr_q + IPF_INC_2DW;
            pend_d[own] = 1'b1;
            req_d = 1'b1;
            fs_d = IPF_FS_REQ;
          end
        end
      end
      IPF_FS_REQ: begin
        if (fetch_ack) begin
          req_d = 1'b0;
          fs_d = IPF_FS_IDLE;
          busy_d[route_sel_q] = 1'b1;
          tgt_d[route_sel_q] = addr_latch_q[IPF_PAR_BIT];
          stale_d[route_sel_q] = req_stale_q || redirect;
          rsel_d = ~route_sel_q;
          rstale_d = 1'b0;
        end
      end
      default: begin
        fs_d = IPF_FS_IDLE;
        req_d = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // opcode stage registers
  // ----------------------------------------------------------------
  // fast unit gets the register-to-register class, the rest go to exec
  always_comb begin
    fast_d = fast_q;
    exec_d = exec_q;
    put_d = put_q;
    op2_d = op2_q;
    op3_d = op3_q;
    is3_d = is3_q;
    ss_act_d = ss_act_q;
    ss_done_d = 1'b0;
    if (do_disp) begin
      if (front_q[IPF_OP_HI -: 2] == IPF_FMT_RR) begin
        fast_d = front_q[IPF_OP_HI:IPF_RF_LO];
      end else begin
        exec_d = front_q[IPF_OP_HI:IPF_OP_LO];
      end
      put_d = front_q[IPF_RF_HI:IPF_RF_LO];
      op2_d = front_q[15:0];
      op3_d = third_q;
      is3_d = front_len == 3'h3;
      ss_act_d = front_q[IPF_OP_HI -: 2] == IPF_FMT_SS;
    end else if (ss_act_q && len1_done && len2_done) begin
      ss_act_d = 1'b0;
      ss_done_d = 1'b1;
    end
    // last cycle copy lets exec take the next opcode early
    last_d = first_exec_cycle ? exec_q : last_q;
    opnd_d = (third_hw_need && is3_q) ? op3_q : op2_q;
  end

  ipf_len_ctr #(.W(4)) u_len1 (
    .pclk(pclk),
    .presetn(presetn),
    .load(do_disp && front_q[IPF_OP_HI -: 2] == IPF_FMT_SS),
    .load_val(front_q[IPF_RF_HI:IPF_RF_LO]),
    .dec(len1_dec),
    .count(len1_cnt),
    .done(len1_done)
  );

  ipf_len_ctr #(.W(4)) u_len2 (
    .pclk(pclk),
    .presetn(presetn),
    .load(do_disp && front_q[IPF_OP_HI -: 2] == IPF_FMT_SS),
    .load_val(front_q[IPF_L2_HI:IPF_L2_LO]),
    .dec(len2_dec),
    .count(len2_cnt),
    .done(len2_done)
  );

  // ----------------------------------------------------------------
  // apb slave, one wait state on every access
  // ----------------------------------------------------------------
  always_comb begin
    pready_d = psel && penable && !pready_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    enable_d = enable_q;
    if (psel && penable && !pready_q) begin
      prdata_d = 32'h00000000;
      case (paddr)
        IPF_OFF_COUNTER: prdata_d = {8'h00, ctr_q};
        IPF_OFF_STATUS: prdata_d = {20'h00000, !need_ok && !front_valid_q, fetch_req_q,
                                    route_busy_q, pend_q, buf_vld, front_valid_q, gs};
        IPF_OFF_FRONT: prdata_d = front_q;
        IPF_OFF_OPCODES: prdata_d = {4'h0, fast_q, exec_q, last_q};
        IPF_OFF_LENGTHS: prdata_d = {20'h00000, put_q, len1_cnt, len2_cnt};
        IPF_OFF_CTRL: prdata_d = {31'h00000000, enable_q};
        default: pslverr_d = 1'b1;
      endcase
    end
    if (apb_done && pwrite && paddr == IPF_OFF_CTRL) begin
      enable_d = pwdata[IPF_CTRL_EN];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctr_q <= IPF_CTR_RST;
      addr_latch_q <= IPF_CTR_RST;
      enable_q <= IPF_EN_RST;
      front_valid_q <= 1'b0;
      front_q <= 32'h00000000;
      third_q <= 16'h0000;
      pend_q <= 2'b00;
      fs_q <= IPF_FS_IDLE;
      fetch_req_q <= 1'b0;
      route_sel_q <= 1'b0;
      route_busy_q <= 2'b00;
      route_tgt_q <= 2'b00;
      route_stale_q <= 2'b00;
      req_stale_q <= 1'b0;
      ret_latch_q <= 64'h0000000000000000;
      ret_vld_q <= 1'b0;
      ret_route_q <= 1'b0;
      fast_q <= 12'h000;
      exec_q <= 8'h00;
      last_q <= 8'h00;
      put_q <= 4'h0;
      op2_q <= 16'h0000;
      op3_q <= 16'h0000;
      opnd_q <= 16'h0000;
      is3_q <= 1'b0;
      disp_q <= 1'b0;
      ss_act_q <= 1'b0;
      ss_done_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctr_q <= ctr_d;
      addr_latch_q <= addr_d;
      enable_q <= enable_d;
      front_valid_q <= front_valid_d;
      front_q <= front_d;
      third_q <= third_d;
      pend_q <= pend_d;
      fs_q <= fs_d;
      fetch_req_q <= req_d;
      route_sel_q <= rsel_d;
      route_busy_q <= busy_d;
      route_tgt_q <= tgt_d;
      route_stale_q <= stale_d;
      req_stale_q <= rstale_d;
      ret_latch_q <= ret_latch_d;
      ret_vld_q <= ret_valid;
      ret_route_q <= ret_route;
      fast_q <= fast_d;
      exec_q <= exec_d;
      last_q <= last_d;
      put_q <= put_d;
      op2_q <= op2_d;
      op3_q <= op3_d;
      opnd_q <= opnd_d;
      is3_q <= is3_d;
      disp_q <= do_disp;
      ss_act_q <= ss_act_d;
      ss_done_q <= ss_done_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // byte select bits stay behind in the address latch
  assign fetch_dw_addr = addr_latch_q[23:IPF_DW_LO];
  assign fetch_req = fetch_req_q;
  assign fetch_route = route_sel_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dispatch = disp_q;
  assign fast_exec_opcode = fast_q;
  assign exec_stage_opcode = exec_q;
  assign last_cycle_opcode = last_q;
  assign putaway_reg_select = put_q;
  assign exec_operand_hw = opnd_q;
  assign first_operand_len = len1_cnt;
  assign second_operand_len = len2_cnt;
  assign ss_done = ss_done_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_hw_align;
    @(posedge pclk) disable iff (!presetn) ctr_q[0] == 1'b0;
  endproperty
  a_hw_align: assert property (p_hw_align) else $error("counter off halfword");

  property p_word_lands;
    @(posedge pclk) disable iff (!presetn)
      (ret_vld_q && route_busy_q[ret_route_q] && !route_stale_q[ret_route_q] && !redirect)
      |=> buf_vld[$past(route_tgt_q[ret_route_q])];
  endproperty
  a_word_lands: assert property (p_word_lands) else $error("fetched word not held");

  property p_plus8;
    @(posedge pclk) disable iff (!presetn)
      ($rose(fetch_req_q) && addr_latch_q[3] != $past(ctr_q[3]))
      |-> addr_latch_q == $past(ctr_q) + IPF_INC_DW;
  endproperty
  a_plus8: assert property (p_plus8) else $error("refill not at plus 8");

  property p_plus16;
    @(posedge pclk) disable iff (!presetn)
      ($rose(fetch_req_q) && addr_latch_q != $past(ctr_q) && addr_latch_q[3] == $past(ctr_q[3]))
      |-> addr_latch_q == $past(ctr_q) + IPF_INC_2DW;
  endproperty
  a_plus16: assert property (p_plus16) else $error("refill not at plus 16");

  property p_route_alt;
    @(posedge pclk) disable iff (!presetn)
      (fetch_req_q && fetch_ack) |=> route_sel_q != $past(route_sel_q)
      && route_tgt_q[$past(route_sel_q)] == $past(addr_latch_q[3]);
  endproperty
  a_route_alt: assert property (p_route_alt) else $error("route not alternated");

  property p_front_hold;
    @(posedge pclk) disable iff (!presetn)
      (front_valid_q && !dispatch_ready && !redirect) |=> $stable(front_q) && front_valid_q;
  endproperty
  a_front_hold: assert property (p_front_hold) else $error("front opcode moved");

  property p_carry;
    @(posedge pclk) disable iff (!presetn)
      (do_disp && gs_sum[3]) |=> ctr_q[23:4] == $past(ctr_q[23:4]) + 20'h00001;
  endproperty
  a_carry: assert property (p_carry) else $error("gate carry not added");

  property p_last_cycle;
    @(posedge pclk) disable iff (!presetn)
      first_exec_cycle |=> last_cycle_opcode == $past(exec_q);
  endproperty
  a_last_cycle: assert property (p_last_cycle) else $error("last cycle opcode wrong");

  c_two_out: cover property (@(posedge pclk) disable iff (!presetn) route_busy_q == 2'b11);
  c_carry: cover property (@(posedge pclk) disable iff (!presetn) do_disp && gs_sum[3]);
  c_ss_done: cover property (@(posedge pclk) disable iff (!presetn) ss_done_q);
endmodule
`default_nettype wire

// [ipf_sbc_model.sv]
// storage bus controller model answering instruction fetches
`timescale 1ns/1ps
`default_nettype none
module ipf_sbc_model (
  input wire logic pclk, // machine clock
  input wire logic presetn, // async reset, low
  input wire logic fetch_req, // fetch request
  input wire logic [20:0] fetch_dw_addr, // double word address
  input wire logic fetch_route, // route of request
  output logic fetch_ack, // request taken
  output logic ret_valid, // word returning
  output logic ret_route, // route of word
  output logic [63:0] ret_data // returned word
);
  logic [21:0] pend[$];
  logic [21:0] head;
  // ack then answer in request order; idle data keeps toggling, never stale
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_ack <= 1'b0;
      ret_valid <= 1'b0;
      ret_route <= 1'b0;
      ret_data <= 64'h0;
      pend.delete();
    end else begin
      fetch_ack <= fetch_req & ~fetch_ack;
      if (fetch_req && fetch_ack) begin
        pend.push_back({fetch_route, fetch_dw_addr});
      end
      if (pend.size() > 0 && !ret_valid) begin
        head = pend.pop_front();
        // each word goes back on the route its request carried
        ret_route <= head[21];
        ret_valid <= 1'b1;
        // two-halfword ops; reg field and operand halfword both number the op
        ret_data <= {8'h45, head[2:0], 1'b0, 4'h0, 12'h000, head[2:0], 1'b0,
                     8'h45, head[2:0], 1'b1, 4'h0, 12'h000, head[2:0], 1'b1};
      end else begin
        ret_valid <= 1'b0;
        ret_data <= ~ret_data;
      end
    end
  end
endmodule
`default_nettype wire

// [ipf_top_tb_top.sv]
// self-checking bench for the prefetch front end
`timescale 1ns/1ps
`default_nettype none
module ipf_top_tb_top;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, rdy, e, fec;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, fetch_req, fetch_route, fetch_ack, ret_valid, ret_route, dispatch;
  logic [20:0] fetch_dw_addr;
  logic [20:0] fa[8];
  logic [63:0] ret_data;
  logic [7:0] exec_stage_opcode;
  logic [3:0] putaway_reg_select;
  logic [15:0] opnd;
  int n_errors = 0;
  int cmp_count = 0;
  int nf = 0;
  int n;
  always #12.5 pclk = ~pclk;
  ipf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetch_req(fetch_req), .fetch_dw_addr(fetch_dw_addr),
    .fetch_route(fetch_route), .fetch_ack(fetch_ack), .ret_valid(ret_valid),
    .ret_route(ret_route), .ret_data(ret_data), .dispatch_ready(rdy),
    .first_exec_cycle(fec), .third_hw_need(rdy), .len1_dec(fec), .len2_dec(fec),
    .dispatch(dispatch), .fast_exec_opcode(), .exec_stage_opcode(exec_stage_opcode),
    .last_cycle_opcode(), .putaway_reg_select(putaway_reg_select), .exec_operand_hw(opnd),
    .first_operand_len(), .second_operand_len(), .ss_done());
  ipf_sbc_model i_sbc (.pclk(pclk), .presetn(presetn), .fetch_req(fetch_req),
    .fetch_dw_addr(fetch_dw_addr), .fetch_route(fetch_route), .fetch_ack(fetch_ack),
    .ret_valid(ret_valid), .ret_route(ret_route), .ret_data(ret_data));
  // note the first eight accepted fetch addresses
  always @(posedge pclk) begin
    if (fetch_req === 1'b1 && fetch_ack === 1'b1 && nf < 8) begin
      fa[nf] = fetch_dw_addr;
      nf++;
    end
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    if (k >= 20) begin
      n_errors++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; rdy = 1'b0;
    fec = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 8'h00, 32'h00000100);
    apb(1'b1, 8'h14, 32'h00000001);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(r, 32'h00000100);
    $display("register test done");
    rdy <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (dispatch !== 1'b1 && n < 200);
      if (n >= 200) begin
        n_errors++;
        close_out();
      end
      chk({28'h0, putaway_reg_select}, i);
      chk({24'h0, exec_stage_opcode}, 32'h45);
      // first exec cycle pulse; operand register follows one cycle later
      fec <= 1'b1;
      @(posedge pclk);
      fec <= 1'b0;
      chk({16'h0, opnd}, i);
    end
    rdy <= 1'b0;
    for (int i = 0; i < 4; i++) chk({11'h0, fa[i]}, 32'h20 + i);
    apb(1'b0, 8'h0C, 32'h0);
    chk(r, 32'h00004545);
    $display("prefetch and dispatch test done");
    close_out();
  end
endmodule
`default_nettype wire
